// ---- gpo_pkg.sv ----
// shared constants and types for the six-pin output port
package gpo_pkg;

  localparam int PORT_W = 6;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 4;
  localparam int HI_LSB = 8;

  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_LEVEL    = 16'hf210;
  localparam logic [15:0] IDX_DRV_LO   = 16'hf212;
  localparam logic [15:0] IDX_DRV_HI   = 16'hf213;
  localparam logic [15:0] IDX_FUNC     = 16'hf214;
  localparam logic [15:0] IDX_DRV_WORD = 16'hf215;

  localparam logic [PORT_W-1:0] FIELD_RESET = 6'h00;
  localparam logic [PORT_W-1:0] ALL_PINS    = 6'h3f;

  // pin 2 has no secondary source
  localparam int NO_ALT_PIN = 2;
  localparam logic [PORT_W-1:0] ALT_MASK = 6'h3b;

  typedef enum logic [1:0] {
    DRIVE_HIZ,
    DRIVE_PCH_OD,
    DRIVE_NCH_OD,
    DRIVE_CMOS
  } drive_mode_t;

endpackage : gpo_pkg

// ---- level_sync.sv ----
// two-stage synchroniser bank for levels from other clock domains
module level_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clock_i, // system clock
  input  wire logic             rst_i,   // async reset, active high
  input  wire logic [WIDTH-1:0] async_i, // foreign-domain levels
  output logic      [WIDTH-1:0] sync_o   // synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage is read only by the second stage
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : level_sync

// ---- pin_drive.sv ----
// one pin's driver: turns level and drive mode into out and enable
module pin_drive (
  input  wire logic               clock_i,  // system clock
  input  wire logic               rst_i,    // async reset, active high
  input  wire logic               level_i,  // level to present
  input  gpo_pkg::drive_mode_t    mode_i,   // driver mode
  output logic                    pin_o,    // pad output value
  output logic                    pin_oe_o  // pad output enable
);

  logic out_d;
  logic oe_d;
  logic out_q;
  logic oe_q;

  always_comb
  begin
    out_d = 1'b0;
    oe_d  = 1'b0;
    unique case (mode_i)
      gpo_pkg::DRIVE_HIZ:
      begin
        out_d = 1'b0;
        oe_d  = 1'b0;
      end
      gpo_pkg::DRIVE_PCH_OD:
      begin
        out_d = 1'b1;
        oe_d  = level_i;
      end
      gpo_pkg::DRIVE_NCH_OD:
      begin
        out_d = 1'b0;
        oe_d  = ~level_i;
      end
      gpo_pkg::DRIVE_CMOS:
      begin
        out_d = level_i;
        oe_d  = 1'b1;
      end
    endcase
  end

  // registered so the pad never sees decode glitches
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_o    = out_q;
  assign pin_oe_o = oe_q;

endmodule : pin_drive

// ---- pin_load.sv ----
// pull-up loads and leds hanging on the six output pads
module pin_load (
  input  wire logic [5:0] pin_i,   // pad output values
  input  wire logic [5:0] pin_oe_i, // pad output enables
  output logic      [5:0] pad_o,   // resolved pad levels
  output logic      [5:0] led_on_o // led lit when pad sinks
);
  // undriven pads float up, so a stale drive value is never seen
  assign pad_o = (pin_oe_i & pin_i) | ~pin_oe_i;
  // led from supply to pad, lit by a low pad
  assign led_on_o = ~pad_o;
endmodule : pin_load

// ---- six_bit_output_port.sv ----
// six-pin output port with wishbone registers and secondary sources
//
// Operation
// - in cmos mode each pin follows its data bit, 0 low and 1 high
// - data register reads back the written value, not the pins
// - control pair per pin: 00 hiz, 01 p-open, 10 n-open, 11 cmos
// - high-impedance mode turns both drivers off regardless of data
// - all four registers reset to zero: hiz, primary, low
// - select bit 0 makes the pin a plain output of its data bit
// - select bit 0 set routes slow clock to pin 0
// - select bit 1 set routes fast clock to pin 1
// - select bit 3 set routes pwm channel a to pin 3
// - select bit 4 set routes pwm channel b to pin 4
// - driver registers adjacent, low first; byte or 16-bit access
// - select bit 5 set routes pwm channel c to pin 5
// - output only: no direction register, no pin input path
module six_bit_output_port #(
  parameter int ADDR_W = 18
) (
  input  wire logic                  clock_i,            // system clock
  input  wire logic                  rst_i,              // async reset
  input  wire logic [ADDR_W-1:0]     wb_adr_i,           // byte address
  input  wire logic [31:0]           wb_dat_i,           // write data
  output logic      [31:0]           wb_dat_o,           // read data
  input  wire logic                  wb_we_i,            // write enable
  input  wire logic [3:0]            wb_sel_i,           // byte lanes
  input  wire logic                  wb_cyc_i,           // bus cycle
  input  wire logic                  wb_stb_i,           // strobe
  output logic                       wb_ack_o,           // acknowledge
  input  wire logic                  slow_clock_out_i,   // slow clock
  input  wire logic                  fast_clock_out_i,   // fast clock
  input  wire logic                  pulse_width_ch_a_i, // pwm a
  input  wire logic                  pulse_width_ch_b_i, // pwm b
  input  wire logic                  pulse_width_ch_c_i, // pwm c
  output logic      [5:0]            port_pin_o,         // pad values
  output logic      [5:0]            port_pin_oe_o       // pad enables
);

  localparam int PW = gpo_pkg::PORT_W;

  logic [PW-1:0] level_q;
  logic [PW-1:0] drv_lo_q;
  logic [PW-1:0] drv_hi_q;
  logic [PW-1:0] func_q;
  logic          ack_q;
  logic [31:0]   rdat_q;
  logic [31:0]   rdat_d;
  logic [15:0]   idx;
  logic          req;
  logic          wr;
  logic          hit_level;
  logic          hit_lo;
  logic          hit_hi;
  logic          hit_func;
  logic          hit_word;
  logic [PW-1:0] alt_raw;
  logic [PW-1:0] alt_sync;
  logic [PW-1:0] pin_value;

  assign idx = wb_adr_i[ADDR_W-1:2];
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  // write lands on the edge where the master sees ack
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  assign hit_level = (idx == gpo_pkg::IDX_LEVEL);
  assign hit_lo    = (idx == gpo_pkg::IDX_DRV_LO);
  assign hit_hi    = (idx == gpo_pkg::IDX_DRV_HI);
  assign hit_func  = (idx == gpo_pkg::IDX_FUNC);
  assign hit_word  = (idx == gpo_pkg::IDX_DRV_WORD);

  // one ack per request; unmapped addresses are acked with zero data
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      level_q <= gpo_pkg::FIELD_RESET;
    else if (wr && hit_level && wb_sel_i[0])
      level_q <= wb_dat_i[PW-1:0];
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      drv_lo_q <= gpo_pkg::FIELD_RESET;
    else if (wr && hit_lo && wb_sel_i[0])
      drv_lo_q <= wb_dat_i[PW-1:0];
    else if (wr && hit_word && wb_sel_i[0])
      drv_lo_q <= wb_dat_i[PW-1:0];
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      drv_hi_q <= gpo_pkg::FIELD_RESET;
    else if (wr && hit_hi && wb_sel_i[0])
      drv_hi_q <= wb_dat_i[PW-1:0];
    else if (wr && hit_word && wb_sel_i[1])
      drv_hi_q <= wb_dat_i[gpo_pkg::HI_LSB +: PW];
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      func_q <= gpo_pkg::FIELD_RESET;
    else if (wr && hit_func && wb_sel_i[0])
      func_q <= wb_dat_i[PW-1:0];
  end

  always_comb
  begin
    rdat_d = '0;
    if (hit_level)
      rdat_d = 32'(level_q);
    else if (hit_lo)
      rdat_d = 32'(drv_lo_q);
    else if (hit_hi)
      rdat_d = 32'(drv_hi_q);
    else if (hit_func)
      rdat_d = 32'(func_q);
    else if (hit_word)
      rdat_d = 32'(drv_lo_q) | (32'(drv_hi_q) << gpo_pkg::HI_LSB);
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rdat_q <= '0;
    else if (req && !wb_we_i)
      rdat_q <= rdat_d;
    else
      rdat_q <= '0;
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // clocks and pwm arrive from other domains, so they are synchronised;
  // a clock much faster than clock_i will alias on the pad
  // per-pin sources
  assign alt_raw = {pulse_width_ch_c_i, pulse_width_ch_b_i,
                    pulse_width_ch_a_i, 1'b0,
                    fast_clock_out_i, slow_clock_out_i};

  level_sync #(
    .WIDTH (PW)
  ) u_alt_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (alt_raw),
    .sync_o  (alt_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++)
    begin : g_pin
      if (gi == gpo_pkg::NO_ALT_PIN)
      begin : g_plain
        assign pin_value[gi] = level_q[gi];
      end
      else
      begin : g_alt
        assign pin_value[gi] = func_q[gi] ? alt_sync[gi] : level_q[gi];
      end

      pin_drive u_drive (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .level_i  (pin_value[gi]),
        .mode_i   (gpo_pkg::drive_mode_t'({drv_hi_q[gi], drv_lo_q[gi]})),
        .pin_o    (port_pin_o[gi]),
        .pin_oe_o (port_pin_oe_o[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");

  cmos_level_a: assert property (
    (func_q == '0 && (drv_lo_q & drv_hi_q) == gpo_pkg::ALL_PINS)
    |=> (port_pin_o == $past(level_q)
         && port_pin_oe_o == gpo_pkg::ALL_PINS))
    else $error("cmos pins do not follow data");

  readback_a: assert property (
    (wb_ack_o && !wb_we_i && hit_level)
    |-> wb_dat_o == 32'(level_q))
    else $error("data register readback wrong");

  ndrain_a: assert property (
    (drv_hi_q[0] && !drv_lo_q[0] && !func_q[0])
    |=> (!port_pin_o[0] && port_pin_oe_o[0] == !$past(level_q[0])))
    else $error("n-channel open drain decode wrong");

  hiz_off_a: assert property (
    1'b1 |=> (port_pin_oe_o & ~$past(drv_hi_q | drv_lo_q)) == '0)
    else $error("pin driven in high impedance mode");

  reset_zero_a: assert property (
    @(posedge clock_i) disable iff (1'b0)
    rst_i |-> (level_q == '0 && drv_lo_q == '0 && drv_hi_q == '0
               && func_q == '0 && port_pin_oe_o == '0 && !wb_ack_o))
    else $error("registers not zero in reset");

  primary_a: assert property (
    (!func_q[3] && drv_hi_q[3] && !drv_lo_q[3])
    |=> port_pin_oe_o[3] == !$past(level_q[3]))
    else $error("primary output on pin 3 wrong");

  alt_route_a: assert property (
    1'b1 |=> ((port_pin_o ^ $past(alt_sync))
              & $past(func_q & drv_lo_q & drv_hi_q)
              & gpo_pkg::ALT_MASK) == '0)
    else $error("secondary source not routed");

  pin2_plain_a: assert property (
    (drv_hi_q[2] && drv_lo_q[2])
    |=> port_pin_o[2] == $past(level_q[2]))
    else $error("pin 2 left its data bit");

  word_write_a: assert property (
    (wr && hit_word && wb_sel_i[1:0] == 2'b11)
    |=> (drv_lo_q == $past(wb_dat_i[PW-1:0])
         && drv_hi_q == $past(wb_dat_i[gpo_pkg::HI_LSB +: PW])))
    else $error("word write missed a byte");

  upper_zero_a: assert property (
    wb_dat_o[7:6] == 2'b00 && wb_dat_o[31:14] == '0)
    else $error("unimplemented bits read nonzero");

  alt_mode_a: assert property (
    (func_q[5] && !drv_hi_q[5] && drv_lo_q[5])
    |=> (port_pin_o[5] && port_pin_oe_o[5] == $past(alt_sync[5])))
    else $error("pwm c bypassed p-channel mode");

  pchan_drive_a: assert property (
    (!drv_hi_q[1] && drv_lo_q[1] && !func_q[1])
    |=> (port_pin_o[1] && port_pin_oe_o[1] == $past(level_q[1])))
    else $error("p-channel open drain decode wrong");

  fast_route_a: assert property (
    (func_q[1] && drv_hi_q[1] && drv_lo_q[1])
    |=> port_pin_o[1] == $past(alt_sync[1]))
    else $error("fast clock not on pin 1");

  level_write_a: assert property (
    (wr && hit_level && wb_sel_i[0])
    |=> level_q == $past(wb_dat_i[PW-1:0]))
    else $error("data register write lost");

  func_write_a: assert property (
    (wr && hit_func && wb_sel_i[0])
    |=> func_q == $past(wb_dat_i[PW-1:0]))
    else $error("function select write lost");

  word_read_a: assert property (
    (wb_ack_o && !wb_we_i && hit_word)
    |-> (wb_dat_o[PW-1:0] == drv_lo_q
         && wb_dat_o[gpo_pkg::HI_LSB +: PW] == drv_hi_q))
    else $error("word read does not join both bytes");

  lane_keep_a: assert property (
    (wr && hit_word && !wb_sel_i[0])
    |=> $stable(drv_lo_q))
    else $error("word write touched an unselected byte");

  idle_data_a: assert property (
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside the ack cycle");

  ack_cause_a: assert property (
    wb_ack_o |-> $past(req))
    else $error("ack without a request");

  word_seen_c: cover property (wr && hit_word && wb_sel_i[1:0] == 2'b11);
  slow_out_c: cover property (func_q[0] && drv_lo_q[0] && drv_hi_q[0]);
  read_data_c: cover property (wb_ack_o && !wb_we_i && hit_level);
  led_drive_c: cover property (drv_hi_q[4] && !drv_lo_q[4] && !func_q[4]);
  pch_alt_c: cover property (func_q[5] && drv_lo_q[5] && !drv_hi_q[5]);

endmodule : six_bit_output_port

// ---- testbench.sv ----
// self-checking bench for the six-pin output port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [17:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd, rd;
  logic [3:0]  wb_sel_i;
  logic [4:0]  src_q;
  logic [5:0]  pin, oe, pad, led, lo, hi, dat, fsel;
  int          err_total, checked, cycles;
  six_bit_output_port DUT (.clock_i(clock_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .slow_clock_out_i(src_q[0]), .fast_clock_out_i(src_q[1]),
    .pulse_width_ch_a_i(src_q[2]), .pulse_width_ch_b_i(src_q[3]),
    .pulse_width_ch_c_i(src_q[4]), .port_pin_o(pin), .port_pin_oe_o(oe));
  pin_load load (.pin_i(pin), .pin_oe_i(oe), .pad_o(pad), .led_on_o(led));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // request held until ack is sampled, released on that same edge
  task automatic bus(input logic [15:0] idx, input logic w,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clock_i);
    wb_adr_i <= {idx, 2'b00};
    wb_we_i  <= w;
    wb_dat_i <= d;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  // pads compared against the drive-mode table and source selection
  task automatic pads_chk();
    logic [5:0] sel, alt, l, e, o, p, n;
    // sources settle through two sync flops and the pad flop first
    repeat (4) @(posedge clock_i);
    sel = fsel & gpo_pkg::ALT_MASK;
    alt = {src_q[4:2], 1'b0, src_q[1:0]};
    l = (sel & alt) | (~sel & dat);
    e = (~hi & lo & l) | (hi & ~lo & ~l) | (hi & lo);
    o = (lo & ~hi) | (hi & lo & l);
    // six-bit pad image, kept narrow so inversion cannot spill
    p = (e & o) | ~e;
    n = ~p;
    chk("pad enable", e, oe);
    chk("pad level", p, pad);
    chk("led lit", n, led);
  endtask : pads_chk
  // pad enables and every register at their reset state
  task automatic zero_chk();
    chk("reset enables", 6'h00, oe);
    for (int i = 0; i < 4; i++)
    begin
      bus(i == 0 ? gpo_pkg::IDX_LEVEL : gpo_pkg::IDX_DRV_LO + 16'(i - 1),
          1'b0, '0, 4'hf);
      chk("reset value", 32'h0, rd);
    end
  endtask : zero_chk
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  initial
  begin
    {rst_i, wb_adr_i, wb_dat_i, wb_we_i, wb_sel_i} = '1;
    {wb_cyc_i, wb_stb_i, src_q} = '0;
    rnd = 32'h8ecf3870;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    zero_chk();
    bus(16'hf211, 1'b0, '0, 4'hf);
    chk("unmapped read", 32'h0, rd);
    fsel = '0;
    // every drive mode through the word alias, led mode included
    for (int m = 0; m < 8; m++)
    begin
      rnd = lfsr(rnd);
      lo = {6{m[0]}};
      hi = {6{m[1]}};
      dat = (m > 3) ? rnd[5:0] : ~rnd[5:0];
      bus(gpo_pkg::IDX_DRV_WORD, 1'b1, {18'h0, hi, 2'b00, lo}, 4'h3);
      bus(gpo_pkg::IDX_LEVEL, 1'b1, {rnd[31:6], dat}, 4'h1);
      pads_chk();
      bus(gpo_pkg::IDX_LEVEL, 1'b0, '0, 4'hf);
      chk("data readback", {26'h0, dat}, rd);
    end
    // upper lane alone leaves the low driver byte untouched
    bus(gpo_pkg::IDX_DRV_WORD, 1'b1, 32'h0000_0a15, 4'h2);
    hi = 6'h0a;
    bus(gpo_pkg::IDX_DRV_WORD, 1'b0, '0, 4'hf);
    chk("word readback", {18'h0, hi, 2'b00, lo}, rd);
    for (int i = 0; i < 24; i++)
    begin
      rnd = lfsr(rnd);
      {fsel, hi, lo, dat} = rnd[23:0];
      // corners: every source in p-channel, then in cmos
      if (i < 2)
      begin
        fsel = 6'h3f;
        lo   = 6'h3f;
        hi   = (i == 0) ? 6'h00 : 6'h3f;
      end
      fsel = fsel & gpo_pkg::ALT_MASK;
      bus(gpo_pkg::IDX_DRV_LO, 1'b1, {rnd[31:8], 2'b11, lo}, 4'h1);
      bus(gpo_pkg::IDX_DRV_HI, 1'b1, {rnd[31:8], 2'b11, hi}, 4'h1);
      bus(gpo_pkg::IDX_LEVEL, 1'b1, {26'h0, dat}, 4'h1);
      bus(gpo_pkg::IDX_FUNC, 1'b1, {24'h0, 2'b11, fsel}, 4'h1);
      rnd = lfsr(rnd);
      src_q <= rnd[4:0];
      pads_chk();
      bus(gpo_pkg::IDX_FUNC, 1'b0, '0, 4'hf);
      chk("select readback", {26'h0, fsel}, rd);
      bus(gpo_pkg::IDX_DRV_HI, 1'b0, '0, 4'hf);
      chk("high readback", {26'h0, hi}, rd);
    end
    // reset in mid-run must clear every configured register
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    zero_chk();
    final_report();
  end
endmodule : testbench
